// ==== verilog/hlu_params.svh ====
// constants of the head load/unload sequencer: offsets, field positions, timing
`ifndef HLU_PARAMS_SVH
`define HLU_PARAMS_SVH

// clock rate
`define HLU_CLK_MHZ 125

// timing figures in their own units
`define HLU_BRUSH_TIME_MS 20000
`define HLU_INDEX_PULSE_NS 55000
`define HLU_PAIR_WIN_NS 200000
`define HLU_MIN_RPM 2000

// derived cycle counts, 64-bit math to avoid overflow
`define HLU_BRUSH_CYC ((64'd`HLU_BRUSH_TIME_MS * 64'd1000 * 64'd`HLU_CLK_MHZ))
`define HLU_INDEX_PULSE_CYC ((64'd`HLU_INDEX_PULSE_NS * 64'd`HLU_CLK_MHZ) / 64'd1000)
`define HLU_PAIR_WIN_CYC ((64'd`HLU_PAIR_WIN_NS * 64'd`HLU_CLK_MHZ) / 64'd1000)
`define HLU_MAX_REV_CYC ((64'd60 * 64'd1000000 * 64'd`HLU_CLK_MHZ) / 64'd`HLU_MIN_RPM)

// register byte offsets
`define HLU_OFF_CTRL 8'h00
`define HLU_OFF_STATUS 8'h04
`define HLU_OFF_IRQ_STAT 8'h08
`define HLU_OFF_IRQ_MASK 8'h0C
`define HLU_OFF_REV_PERIOD 8'h10

// control register fields
`define HLU_CTRL_UNSECT 0
`define HLU_CTRL_RESTART 1

// status register fields
`define HLU_ST_STATE_LSB 0
`define HLU_ST_STATE_MSB 7
`define HLU_ST_SPEED_EN 8
`define HLU_ST_SPEED_OK 9
`define HLU_ST_READY 10
`define HLU_ST_UNLOADED_SW 11
`define HLU_ST_POWER 12

// interrupt event bits
`define HLU_IRQ_W 6
`define HLU_IRQ_READY 0
`define HLU_IRQ_RETRACT 1
`define HLU_IRQ_HALTED 2
`define HLU_IRQ_BRUSH_TO 3
`define HLU_IRQ_INDEX 4
`define HLU_IRQ_SPEED_LOST 5

// reset values
`define HLU_CTRL_RST 2'h0
`define HLU_MASK_RST 6'h00

`endif

// ==== verilog/hlu_pkg.sv ====
// types shared by the head load/unload sequencer
package hlu_pkg;

  // sequencer states, one-hot
  typedef enum logic [7:0] {
    HLU_OFF     = 8'h01,
    HLU_BRUSH   = 8'h02,
    HLU_WAIT_SP = 8'h04,
    HLU_FWD     = 8'h08,
    HLU_REV     = 8'h10,
    HLU_READY   = 8'h20,
    HLU_RETRACT = 8'h40,
    HLU_FAULT   = 8'h80
  } hlu_state_t;

  typedef logic [7:0] hlu_addr_t;
  typedef logic [31:0] hlu_word_t;

endpackage

// ==== verilog/hlu_index_qual.sv ====
// index transducer qualifier: notch one-shot, index/sector split, rotation speed
`timescale 1ns/1ps
`include "hlu_params.svh"

module hlu_index_qual #(
  parameter logic [31:0] PULSE_CYC = 32'(`HLU_INDEX_PULSE_CYC),
  parameter logic [31:0] PAIR_CYC = 32'(`HLU_PAIR_WIN_CYC),
  parameter logic [31:0] MAX_REV_CYC = 32'(`HLU_MAX_REV_CYC)
) (
  input wire logic core_clk, // system clock
  input wire logic rst, // sync reset, active high
  input wire logic notch, // synchronised notch level
  input wire logic unsectored, // pack has a single index notch
  output logic det_pulse, // fixed-length pulse per notch
  output logic index_pulse, // one-cycle revolution start
  output logic sector_pulse, // one-cycle sector mark
  output logic speed_ok, // rotation fast enough
  output hlu_pkg::hlu_word_t rev_period // cycles of last revolution
);
  import hlu_pkg::*;

  // whole module state
  typedef struct packed {
    logic notch_prev; // edge detect
    logic [31:0] pulse_cnt; // one-shot remaining
    logic det; // one-shot output
    logic pair_open; // waiting for second notch
    logic [31:0] pair_cnt; // pair window remaining
    logic idx; // index event
    logic sec; // sector event
    logic [31:0] rev_cnt; // cycles since index
    logic [31:0] period; // captured revolution time
    logic ok; // speed qualification
  } hlu_iq_t;

  hlu_iq_t q_ff;
  hlu_iq_t nxt_q;
  logic rise;

  assign rise = notch & ~q_ff.notch_prev;

  // next-state logic
  always_comb begin
    nxt_q = q_ff;
    nxt_q.notch_prev = notch;
    nxt_q.idx = 1'b0;
    nxt_q.sec = 1'b0;
    // R8: fixed 55 us one pulse per notch
    if (rise) begin
      nxt_q.pulse_cnt = PULSE_CYC;
    end else if (q_ff.pulse_cnt != 32'h0) begin
      nxt_q.pulse_cnt = q_ff.pulse_cnt - 32'h1;
    end
    nxt_q.det = (nxt_q.pulse_cnt != 32'h0);
    // R10: pair or single notch marks index
    if (unsectored) begin
      nxt_q.pair_open = 1'b0;
      nxt_q.idx = rise;
    end else if (rise) begin
      if (q_ff.pair_open) begin
        // second close notch: index
        nxt_q.idx = 1'b1;
        nxt_q.pair_open = 1'b0;
      end else begin
        // first notch: open the window
        nxt_q.pair_open = 1'b1;
        nxt_q.pair_cnt = PAIR_CYC;
      end
    end else if (q_ff.pair_open) begin
      // R11: lone notch is a sector mark
      if (q_ff.pair_cnt <= 32'h1) begin
        nxt_q.sec = 1'b1;
        nxt_q.pair_open = 1'b0;
      end
      nxt_q.pair_cnt = q_ff.pair_cnt - 32'h1;
    end
    // R9: revolution time decides speed
    if (nxt_q.idx) begin
      nxt_q.period = q_ff.rev_cnt;
      nxt_q.ok = (q_ff.rev_cnt <= MAX_REV_CYC);
      nxt_q.rev_cnt = 32'h0;
    end else begin
      if (q_ff.rev_cnt <= MAX_REV_CYC) begin
        nxt_q.rev_cnt = q_ff.rev_cnt + 32'h1;
      end else begin
        // no index in time: too slow
        nxt_q.ok = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign det_pulse = q_ff.det;
  assign index_pulse = q_ff.idx;
  assign sector_pulse = q_ff.sec;
  assign speed_ok = q_ff.ok;
  assign rev_period = q_ff.period;
endmodule

// ==== verilog/hlu_sequencer.sv ====
// head load/unload sequencer for a removable-pack disk drive
// How it works
// R1: no data exchange until heads loaded
// R2: power up starts spindle, brush, waits
// R3: continue only with speed qualification asserted
// R4: after brush, seek forward loading heads
// R5: forward to end of travel, back 00
// R6: heads switch means unloaded only retracted
// R7: speed enable drop retracts carriage, halts
// R8: 55 us pulse per sector notch
// R9: index timing decides rotation speed good
// R10: notch pair or single notch marks index
// R11: other notches become separate sector marks
// R12: speed loss mid-load aborts into retract
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "hlu_params.svh"

module hlu_sequencer #(
  parameter logic [31:0] BRUSH_CYC = 32'(`HLU_BRUSH_CYC),
  parameter logic [31:0] PULSE_CYC = 32'(`HLU_INDEX_PULSE_CYC),
  parameter logic [31:0] PAIR_CYC = 32'(`HLU_PAIR_WIN_CYC),
  parameter logic [31:0] MAX_REV_CYC = 32'(`HLU_MAX_REV_CYC)
) (
  input wire logic core_clk, // system clock
  input wire logic rst, // sync reset, active high
  input wire hlu_pkg::hlu_addr_t addr, // register byte address
  input wire hlu_pkg::hlu_word_t wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output hlu_pkg::hlu_word_t rdata, // read data, cycle after rd
  output logic irq, // level interrupt
  input wire logic deck_power, // deck power present pin
  input wire logic speed_relay, // speed relay energised pin
  input wire logic brush_home, // brush reset switch pin
  input wire logic fwd_eot, // forward end of travel pin
  input wire logic track_zero, // carriage at track 00 pin
  input wire logic unloaded_sw, // heads loaded switch, high=unloaded
  input wire logic index_notch, // index transducer pin
  output logic spindle_on, // spindle drive on
  output logic brush_motor_on, // brush motor on
  output logic carriage_fwd, // drive carriage forward
  output logic carriage_rev, // drive carriage reverse
  output logic heads_ready, // data exchange allowed
  output logic index_det, // notch one-shot
  output logic index_pulse, // revolution start
  output logic sector_pulse // sector mark
);
  import hlu_pkg::*;

  localparam int NSYNC = 7; // synchronised pins

  // whole module state
  typedef struct packed {
    logic [NSYNC-1:0] sync1; // first sync stage
    logic [NSYNC-1:0] sync2; // second sync stage
    hlu_state_t state; // sequencer state
    logic power_prev; // power edge detect
    logic speed_prev; // speed_ok fall detect
    logic brush_left; // brushes seen away
    logic [31:0] brush_cnt; // brush timeout counter
    logic spindle; // spindle drive
    logic brush_mot; // brush motor
    logic fwd; // carriage forward
    logic rev; // carriage reverse
    logic ready; // heads loaded, data allowed
    logic [1:0] ctrl; // control register
    logic [`HLU_IRQ_W-1:0] irq_stat; // sticky events
    logic [`HLU_IRQ_W-1:0] irq_mask; // event enables
    hlu_word_t rdata; // read data
    logic irq; // interrupt level
  } hlu_seq_t;

  hlu_seq_t q_ff;
  hlu_seq_t nxt_q;

  // synchronised pins
  logic s_power; // deck power
  logic s_relay; // speed relay
  logic s_brush; // brush home
  logic s_eot; // forward end of travel
  logic s_trk0; // track 00
  logic s_unld; // unloaded switch
  logic s_notch; // index notch

  // index qualifier outputs
  logic iq_det;
  logic iq_idx;
  logic iq_sec;
  logic iq_ok;
  hlu_word_t iq_period;

  logic speed_en; // combined speed enable
  logic [`HLU_IRQ_W-1:0] ev; // events this cycle

  assign s_power = q_ff.sync2[0];
  assign s_relay = q_ff.sync2[1];
  assign s_brush = q_ff.sync2[2];
  assign s_eot = q_ff.sync2[3];
  assign s_trk0 = q_ff.sync2[4];
  assign s_unld = q_ff.sync2[5];
  assign s_notch = q_ff.sync2[6];

  // R3: power, relay and index speed all needed
  assign speed_en = s_power & s_relay & iq_ok;

  // index transducer qualification
  hlu_index_qual #(
    .PULSE_CYC(PULSE_CYC),
    .PAIR_CYC(PAIR_CYC),
    .MAX_REV_CYC(MAX_REV_CYC)
  ) u_iq (
    .core_clk(core_clk),
    .rst(rst),
    .notch(s_notch),
    .unsectored(q_ff.ctrl[`HLU_CTRL_UNSECT]),
    .det_pulse(iq_det),
    .index_pulse(iq_idx),
    .sector_pulse(iq_sec),
    .speed_ok(iq_ok),
    .rev_period(iq_period)
  );

  // next-state logic
  always_comb begin
    nxt_q = q_ff;
    ev = '0;
    // two-stage pin synchroniser
    nxt_q.sync1 = {index_notch, unloaded_sw, track_zero, fwd_eot,
                   brush_home, speed_relay, deck_power};
    nxt_q.sync2 = q_ff.sync1;
    nxt_q.power_prev = s_power;
    nxt_q.speed_prev = iq_ok;
    nxt_q.ctrl[`HLU_CTRL_RESTART] = 1'b0;

    // sequencer
    case (q_ff.state)
      HLU_OFF: begin
        nxt_q.fwd = 1'b0;
        nxt_q.rev = 1'b0;
        nxt_q.ready = 1'b0;
        // R2: power rise starts spindle and brushes
        if (s_power && (!q_ff.power_prev || q_ff.ctrl[`HLU_CTRL_RESTART])) begin
          nxt_q.spindle = 1'b1;
          nxt_q.brush_mot = 1'b1;
          nxt_q.brush_left = 1'b0;
          nxt_q.brush_cnt = BRUSH_CYC;
          nxt_q.state = HLU_BRUSH;
        end
      end
      HLU_BRUSH: begin
        // brushes away from home at least once
        if (!s_brush) begin
          nxt_q.brush_left = 1'b1;
        end
        if (q_ff.brush_cnt != 32'h0) begin
          nxt_q.brush_cnt = q_ff.brush_cnt - 32'h1;
        end
        if (!s_power) begin
          // R12: abort on power loss
          nxt_q.brush_mot = 1'b0;
          nxt_q.state = HLU_RETRACT;
          ev[`HLU_IRQ_RETRACT] = 1'b1;
        end else if (q_ff.brush_left && s_brush) begin
          // R2: brush cycle finished, brushes clear
          nxt_q.brush_mot = 1'b0;
          nxt_q.state = HLU_WAIT_SP;
        end else if (q_ff.brush_cnt == 32'h0) begin
          // brush never returned: stop, no loading
          nxt_q.brush_mot = 1'b0;
          nxt_q.state = HLU_FAULT;
          ev[`HLU_IRQ_BRUSH_TO] = 1'b1;
        end
      end
      HLU_WAIT_SP: begin
        if (!s_power) begin
          // R12: abort on power loss
          nxt_q.state = HLU_RETRACT;
          ev[`HLU_IRQ_RETRACT] = 1'b1;
        end else if (speed_en) begin
          // R3: speed qualified, R4: start forward seek
          nxt_q.fwd = 1'b1;
          nxt_q.state = HLU_FWD;
        end
      end
      HLU_FWD: begin
        // R6: switch transfer is not taken as loaded
        if (!speed_en) begin
          // R12: speed lost during load
          nxt_q.fwd = 1'b0;
          nxt_q.rev = 1'b1;
          nxt_q.state = HLU_RETRACT;
          ev[`HLU_IRQ_RETRACT] = 1'b1;
        end else if (s_eot) begin
          // R5: end of travel, reverse toward 00
          nxt_q.fwd = 1'b0;
          nxt_q.rev = 1'b1;
          nxt_q.state = HLU_REV;
        end
      end
      HLU_REV: begin
        if (!speed_en) begin
          // R12: speed lost during load
          nxt_q.state = HLU_RETRACT;
          ev[`HLU_IRQ_RETRACT] = 1'b1;
        end else if (s_trk0) begin
          // R5: parked on track 00, heads loaded
          nxt_q.rev = 1'b0;
          nxt_q.ready = 1'b1;
          nxt_q.state = HLU_READY;
          ev[`HLU_IRQ_READY] = 1'b1;
        end
      end
      HLU_READY: begin
        // R7: speed enable drop, retract from here
        if (!speed_en) begin
          nxt_q.ready = 1'b0;
          nxt_q.rev = 1'b1;
          nxt_q.state = HLU_RETRACT;
          ev[`HLU_IRQ_RETRACT] = 1'b1;
        end
      end
      HLU_RETRACT: begin
        nxt_q.fwd = 1'b0;
        nxt_q.ready = 1'b0;
        // R6: only full retraction counts as unloaded
        if (s_unld) begin
          // R7: retracted stop reached, halt
          nxt_q.rev = 1'b0;
          nxt_q.state = HLU_OFF;
          ev[`HLU_IRQ_HALTED] = 1'b1;
        end else begin
          nxt_q.rev = 1'b1;
        end
        if (!s_power) begin
          nxt_q.spindle = 1'b0;
        end
      end
      HLU_FAULT: begin
        // held off until a software restart or deck power loss returns it to off
        nxt_q.fwd = 1'b0;
        nxt_q.rev = 1'b0;
        nxt_q.ready = 1'b0;
        if (q_ff.ctrl[`HLU_CTRL_RESTART] || !s_power) begin
          nxt_q.state = HLU_OFF;
        end
      end
      default: begin
        // illegal code: safe retract
        nxt_q.fwd = 1'b0;
        nxt_q.rev = 1'b1;
        nxt_q.ready = 1'b0;
        nxt_q.state = HLU_RETRACT;
      end
    endcase

    // spindle follows deck power off
    if (!s_power && (q_ff.state != HLU_RETRACT)) begin
      nxt_q.spindle = 1'b0;
    end

    // R1: no data while not parked and qualified
    if (nxt_q.state != HLU_READY) begin
      nxt_q.ready = 1'b0;
    end

    // other events
    ev[`HLU_IRQ_INDEX] = iq_idx;
    ev[`HLU_IRQ_SPEED_LOST] = q_ff.speed_prev & ~iq_ok;

    // register writes
    if (wr) begin
      case (addr)
        `HLU_OFF_CTRL: begin
          nxt_q.ctrl = wdata[1:0];
        end
        `HLU_OFF_IRQ_STAT: begin
          nxt_q.irq_stat = q_ff.irq_stat & ~wdata[`HLU_IRQ_W-1:0];
        end
        `HLU_OFF_IRQ_MASK: begin
          nxt_q.irq_mask = wdata[`HLU_IRQ_W-1:0];
        end
        default: begin
          // unmapped or read-only: ignored
        end
      endcase
    end
    // set wins over a same-cycle clear
    nxt_q.irq_stat = nxt_q.irq_stat | ev;
    nxt_q.irq = |(nxt_q.irq_stat & nxt_q.irq_mask);

    // read data, valid one cycle after rd only
    nxt_q.rdata = '0;
    if (rd) begin
      case (addr)
        `HLU_OFF_CTRL: begin
          nxt_q.rdata[1:0] = q_ff.ctrl;
        end
        `HLU_OFF_STATUS: begin
          nxt_q.rdata[`HLU_ST_STATE_MSB:`HLU_ST_STATE_LSB] = q_ff.state;
          nxt_q.rdata[`HLU_ST_SPEED_EN] = speed_en;
          nxt_q.rdata[`HLU_ST_SPEED_OK] = iq_ok;
          nxt_q.rdata[`HLU_ST_READY] = q_ff.ready;
          nxt_q.rdata[`HLU_ST_UNLOADED_SW] = s_unld;
          nxt_q.rdata[`HLU_ST_POWER] = s_power;
        end
        `HLU_OFF_IRQ_STAT: begin
          nxt_q.rdata[`HLU_IRQ_W-1:0] = q_ff.irq_stat;
        end
        `HLU_OFF_IRQ_MASK: begin
          nxt_q.rdata[`HLU_IRQ_W-1:0] = q_ff.irq_mask;
        end
        `HLU_OFF_REV_PERIOD: begin
          nxt_q.rdata = iq_period;
        end
        default: begin
          // unmapped reads zero
          nxt_q.rdata = '0;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q_ff <= '0;
      q_ff.state <= HLU_OFF;
      q_ff.ctrl <= `HLU_CTRL_RST;
      q_ff.irq_mask <= `HLU_MASK_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // outputs straight from flip-flops
  assign rdata = q_ff.rdata;
  assign irq = q_ff.irq;
  assign spindle_on = q_ff.spindle;
  assign brush_motor_on = q_ff.brush_mot;
  assign carriage_fwd = q_ff.fwd;
  assign carriage_rev = q_ff.rev;
  // R1: data exchange gated by loaded state
  assign heads_ready = q_ff.ready;
  assign index_det = iq_det;
  assign index_pulse = iq_idx;
  assign sector_pulse = iq_sec;
endmodule

// ==== verif/hlu_seq_sva.sv ====
// port assertions for the head load/unload sequencer
`timescale 1ns/1ps
module hlu_seq_sva #(
  parameter logic [31:0] PULSE_CYC = 32'hA
) (
  input wire logic core_clk, // clock
  input wire logic rst, // sync reset
  input wire logic speed_relay, // relay pin
  input wire logic fwd_eot, // end of travel pin
  input wire logic unloaded_sw, // retracted pin
  input wire logic spindle_on, // spindle drive
  input wire logic brush_motor_on, // brush motor
  input wire logic carriage_fwd, // forward drive
  input wire logic carriage_rev, // reverse drive
  input wire logic heads_ready, // loaded and ready
  input wire logic index_det, // notch one-shot
  input wire logic index_pulse, // revolution start
  input wire logic sector_pulse // sector mark
);
  logic [31:0] det_cnt_ff; // high cycles of one-shot
  logic [31:0] nxt_det_cnt; // next count
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // count one-shot length
  always_comb begin
    nxt_det_cnt = index_det ? det_cnt_ff + 32'h1 : 32'h0;
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      det_cnt_ff <= 32'h0;
    end else begin
      det_cnt_ff <= nxt_det_cnt;
    end
  end
  property p_one_dir; !(carriage_fwd && carriage_rev); endproperty
  a_one_dir: assert property (p_one_dir) else $error("carriage driven both ways");
  property p_ready_still; heads_ready |-> !carriage_fwd && !carriage_rev && spindle_on;
  endproperty
  a_ready_still: assert property (p_ready_still) else $error("ready while moving");
  property p_ready_from_rev; $rose(heads_ready) |-> $past(carriage_rev); endproperty
  a_ready_from_rev: assert property (p_ready_from_rev) else $error("ready not after rev");
  property p_fwd_start; $rose(carriage_fwd) |-> !brush_motor_on && $past(speed_relay, 2);
  endproperty
  a_fwd_start: assert property (p_fwd_start) else $error("seek before brush or speed");
  property p_eot_turn; carriage_fwd && fwd_eot |-> ##[1:4] !carriage_fwd; endproperty
  a_eot_turn: assert property (p_eot_turn) else $error("no stop at end of travel");
  property p_halt; carriage_rev && unloaded_sw |-> ##[1:4] !carriage_rev; endproperty
  a_halt: assert property (p_halt) else $error("no halt at retracted stop");
  property p_loss; (heads_ready || carriage_fwd) && !speed_relay |-> ##[1:5] carriage_rev;
  endproperty
  a_loss: assert property (p_loss) else $error("no retract on speed loss");
  property p_det_len; $fell(index_det) |-> det_cnt_ff >= PULSE_CYC; endproperty
  a_det_len: assert property (p_det_len) else $error("detector pulse too short");
  property p_idx_one; index_pulse |=> !index_pulse; endproperty
  a_idx_one: assert property (p_idx_one) else $error("index pulse too long");
  property p_sep; !(index_pulse && sector_pulse); endproperty
  a_sep: assert property (p_sep) else $error("index and sector together");
  property p_brush_pwr; $rose(brush_motor_on) |-> spindle_on; endproperty
  a_brush_pwr: assert property (p_brush_pwr) else $error("brush without spindle");
  c_ready: cover property ($rose(heads_ready));
  c_halt: cover property ($fell(carriage_rev) && unloaded_sw);
  c_sector: cover property (sector_pulse);
endmodule
bind hlu_sequencer hlu_seq_sva #(.PULSE_CYC(PULSE_CYC)) i_sva (
  .core_clk(core_clk), .rst(rst), .speed_relay(speed_relay), .fwd_eot(fwd_eot),
  .unloaded_sw(unloaded_sw), .spindle_on(spindle_on), .brush_motor_on(brush_motor_on),
  .carriage_fwd(carriage_fwd), .carriage_rev(carriage_rev), .heads_ready(heads_ready),
  .index_det(index_det), .index_pulse(index_pulse), .sector_pulse(sector_pulse)
);

// ==== verif/hlu_deck_model.sv ====
// behavioural deck: carriage, brush cycle, speed relay, sector disk
`timescale 1ns/1ps
module hlu_deck_model (
  input wire logic core_clk, // clock
  input wire logic spindle_on, // spindle drive
  input wire logic brush_motor_on, // brush motor
  input wire logic carriage_fwd, // drive forward
  input wire logic carriage_rev, // drive reverse
  input wire logic relay_en, // bench lets relay close
  input wire logic slow, // pack below speed
  input wire logic brush_stuck, // brushes never return
  output logic speed_relay, // relay contact
  output logic brush_home, // brush reset switch
  output logic fwd_eot, // end of travel
  output logic track_zero, // on track 00
  output logic unloaded_sw, // fully retracted
  output logic index_notch // notch under sensor
);
  int pos = 0; // carriage position, 0 is the stop
  int brush_t = 0; // brush cycle time
  int rev_t = 0; // time within revolution
  // one step a cycle, clamped at both ends
  always @(posedge core_clk) begin
    if (carriage_fwd && pos < 40) begin
      pos <= pos + 1;
    end else if (carriage_rev && pos > 0) begin
      pos <= pos - 1;
    end
    brush_t <= brush_motor_on ? brush_t + 1 : 0;
    rev_t <= (!spindle_on || rev_t >= (slow ? 799 : 399)) ? 0 : rev_t + 1;
  end
  // pins follow the mechanics; disk still when spindle off
  always_comb begin
    speed_relay = relay_en && spindle_on;
    brush_home = !(brush_t >= 20 && (brush_stuck || brush_t < 60));
    fwd_eot = pos >= 40;
    track_zero = pos > 0 && pos <= 5;
    unloaded_sw = pos == 0;
    index_notch = spindle_on && ((rev_t % 100) < 3 || (rev_t >= 15 && rev_t < 18));
  end
endmodule

// ==== verif/tb.sv ====
// self-checking bench for the head load/unload sequencer
`timescale 1ns/1ps
`include "hlu_params.svh"
module tb;
  import hlu_pkg::*;
  typedef struct {
    logic w; // write when set
    hlu_addr_t a; // address
    hlu_word_t d; // write data or expected
    hlu_word_t m; // compare mask
  } hlu_tb_row_t;
  logic core_clk = 1'b0; // clock
  logic rst = 1'b1; // reset
  hlu_addr_t addr = 8'h00; // bus address
  hlu_word_t wdata = 32'h0; // bus write data
  logic wr = 1'b0; // write strobe
  logic rd = 1'b0; // read strobe
  logic deck_power = 1'b0; // power pin
  logic relay_en = 1'b0; // model relay allowed
  logic slow = 1'b0; // model pack slow
  logic brush_stuck = 1'b0; // model brush fault
  hlu_word_t rdata; // read data
  logic irq, spindle_on, brush_motor_on, carriage_fwd, carriage_rev, heads_ready;
  logic index_det, index_pulse, sector_pulse, speed_relay, brush_home;
  logic fwd_eot, track_zero, unloaded_sw, index_notch;
  int n_mismatch = 0; // mismatches
  int cmp_count = 0; // comparisons
  int n_wait, n_idx, n_sec; // wait length, pulse counts
  hlu_tb_row_t rows[14] = '{
    '{0, `HLU_OFF_CTRL, 32'h0, 32'hFFFFFFFF}, '{0, `HLU_OFF_STATUS, 32'h801, 32'hFFFFFFFF},
    '{0, `HLU_OFF_IRQ_STAT, 32'h0, 32'hFFFFFFFF}, '{0, `HLU_OFF_IRQ_MASK, 32'h0, 32'hFFFFFFFF},
    '{0, `HLU_OFF_REV_PERIOD, 32'h0, 32'hFFFFFFFF}, '{0, 8'h14, 32'h0, 32'hFFFFFFFF},
    '{1, `HLU_OFF_IRQ_MASK, 32'h2F, 32'h0}, '{0, `HLU_OFF_IRQ_MASK, 32'h2F, 32'hFFFFFFFF},
    '{1, `HLU_OFF_STATUS, 32'hFFFFFFFF, 32'h0}, '{0, `HLU_OFF_STATUS, 32'h801, 32'hFFFFFFFF},
    '{1, 8'h14, 32'hFFFFFFFF, 32'h0}, '{0, 8'h14, 32'h0, 32'hFFFFFFFF},
    '{1, `HLU_OFF_IRQ_STAT, 32'h3F, 32'h0}, '{0, `HLU_OFF_IRQ_STAT, 32'h0, 32'hFFFFFFFF}};
  always #4 core_clk = ~core_clk;
  hlu_sequencer #(.BRUSH_CYC(32'hC8), .PULSE_CYC(32'hA), .PAIR_CYC(32'h14),
    .MAX_REV_CYC(32'h1F4)) i_dut (.core_clk(core_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .deck_power(deck_power),
    .speed_relay(speed_relay), .brush_home(brush_home), .fwd_eot(fwd_eot),
    .track_zero(track_zero), .unloaded_sw(unloaded_sw), .index_notch(index_notch),
    .spindle_on(spindle_on), .brush_motor_on(brush_motor_on), .carriage_fwd(carriage_fwd),
    .carriage_rev(carriage_rev), .heads_ready(heads_ready), .index_det(index_det),
    .index_pulse(index_pulse), .sector_pulse(sector_pulse));
  hlu_deck_model i_model (.core_clk(core_clk), .spindle_on(spindle_on),
    .brush_motor_on(brush_motor_on), .carriage_fwd(carriage_fwd),
    .carriage_rev(carriage_rev), .relay_en(relay_en), .slow(slow),
    .brush_stuck(brush_stuck), .speed_relay(speed_relay), .brush_home(brush_home),
    .fwd_eot(fwd_eot), .track_zero(track_zero), .unloaded_sw(unloaded_sw),
    .index_notch(index_notch));
  // compare and report
  task automatic check(input hlu_word_t seen, input hlu_word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one-cycle write
  task automatic wr_reg(input hlu_addr_t a, input hlu_word_t d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  // read, data checked in the following cycle
  task automatic rd_reg(input hlu_addr_t a, input hlu_word_t e, input hlu_word_t m);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 check(rdata & m, e & m);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return spindle_on;
      1: return carriage_fwd;
      2: return heads_ready;
      3: return carriage_rev;
      4: return !carriage_rev;
      default: return index_pulse;
    endcase
  endfunction
  // bounded wait for an output
  task automatic wait_for(input int s);
    n_wait = 0;
    while (!sig(s) && n_wait < 3000) begin
      @(posedge core_clk);
      #1 n_wait++;
    end
    check(sig(s), 1'b1);
  endtask
  // count index and sector marks
  task automatic count_pulses();
    n_idx = 0;
    n_sec = 0;
    repeat (800) begin
      @(posedge core_clk);
      #1 n_idx += index_pulse;
      n_sec += sector_pulse;
    end
  endtask
  task automatic give_verdict();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (40000) @(posedge core_clk);
    n_mismatch++;
    give_verdict();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr_reg(rows[i].a, rows[i].d);
      end else begin
        rd_reg(rows[i].a, rows[i].d, rows[i].m);
      end
    end
    // power up, brush cycle, load
    @(posedge core_clk);
    deck_power <= 1'b1;
    relay_en <= 1'b1;
    wait_for(0);
    check(brush_motor_on, 1'b1);
    wait_for(1);
    check(n_wait > 50, 1'b1);
    check(brush_motor_on, 1'b0);
    wait_for(2);
    rd_reg(`HLU_OFF_STATUS, 32'h1720, 32'h1FFF);
    // interrupt raised, masked, cleared
    check(irq, 1'b1);
    wr_reg(`HLU_OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge core_clk);
    #1 check(irq, 1'b0);
    rd_reg(`HLU_OFF_IRQ_STAT, 32'h1, 32'h2F);
    wr_reg(`HLU_OFF_IRQ_MASK, 32'h2F);
    repeat (2) @(posedge core_clk);
    #1 check(irq, 1'b1);
    wr_reg(`HLU_OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge core_clk);
    #1 check(irq, 1'b0);
    // sectored then unsectored marks
    wait_for(5);
    count_pulses();
    check(n_idx, 2);
    check(n_sec, 6);
    rd_reg(`HLU_OFF_REV_PERIOD, 32'h18F, 32'hFFFFFFFF);
    wr_reg(`HLU_OFF_CTRL, 32'h1);
    repeat (50) @(posedge core_clk);
    wait_for(5);
    count_pulses();
    check(n_idx, 10);
    check(n_sec, 0);
    wr_reg(`HLU_OFF_CTRL, 32'h0);
    // slow pack unloads heads
    @(posedge core_clk);
    slow <= 1'b1;
    wait_for(3);
    check(heads_ready, 1'b0);
    wait_for(4);
    check(unloaded_sw, 1'b1);
    rd_reg(`HLU_OFF_STATUS, 32'h1, 32'hFF);
    rd_reg(`HLU_OFF_IRQ_STAT, 32'h26, 32'h26);
    // relay drop during forward seek
    @(posedge core_clk);
    slow <= 1'b0;
    wr_reg(`HLU_OFF_IRQ_STAT, 32'h3F);
    wr_reg(`HLU_OFF_CTRL, 32'h2);
    wait_for(1);
    @(posedge core_clk);
    relay_en <= 1'b0;
    wait_for(3);
    check(carriage_fwd, 1'b0);
    check(heads_ready, 1'b0);
    wait_for(4);
    check(unloaded_sw, 1'b1);
    // brushes never home
    @(posedge core_clk);
    relay_en <= 1'b1;
    brush_stuck <= 1'b1;
    wr_reg(`HLU_OFF_CTRL, 32'h2);
    repeat (300) @(posedge core_clk);
    rd_reg(`HLU_OFF_STATUS, 32'h80, 32'hFF);
    rd_reg(`HLU_OFF_IRQ_STAT, 32'h8, 32'h8);
    check(carriage_fwd, 1'b0);
    // power loss stops spindle
    @(posedge core_clk);
    deck_power <= 1'b0;
    brush_stuck <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1 check(spindle_on, 1'b0);
    // reset in mid brush cycle
    @(posedge core_clk);
    deck_power <= 1'b1;
    repeat (30) @(posedge core_clk);
    #1 check(spindle_on, 1'b1);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (10) @(posedge core_clk);
    #1 check(brush_motor_on | spindle_on, 1'b0);
    @(posedge core_clk);
    rst <= 1'b0;
    rd_reg(`HLU_OFF_STATUS, 32'h1, 32'hFF);
    give_verdict();
  end
endmodule
